// ===== verilog/cpf_flush_ctrl.sv
// Eight-stage pipeline valid tracking with interrupt flush and pending logic
`timescale 1ns/100ps
`include "cpf_defines.svh"

module cpf_flush_ctrl #(
    parameter int STAGES = `CPF_STAGES,
    parameter int IRQ_W = `CPF_IRQ_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Fetch path
    input wire logic fetch_valid_i,
    input wire logic isr_return_i,
    output logic fetch_en_o,
    output logic handler_fetch_o,
    output logic [$clog2(IRQ_W)-1:0] handler_id_o,
    output logic [STAGES-1:0] stage_valid_o,
    output logic retire_o,
    // Interrupt source
    input wire logic [IRQ_W-1:0] irq_req_i,
    input wire logic nest_en_i,
    output logic [IRQ_W-1:0] irq_ack_o,
    output logic in_service_o
);
    localparam int IDW = $clog2(IRQ_W);

    // Lowest index wins; a fixed order keeps selection time constant
    function automatic logic [IDW-1:0] prio_pick(input logic [IRQ_W-1:0] v);
        logic [IDW-1:0] r;
        r = '0;
        for (int i = IRQ_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDW'(i);
            end
        end
        return r;
    endfunction

    // ==========================================
    // Input synchronisers
    logic [IRQ_W-1:0] irq_m_ff, irq_s_ff, nxt_irq_m, nxt_irq_s;
    logic nest_m_ff, nest_s_ff, nxt_nest_m, nxt_nest_s;

    always_comb begin
        nxt_irq_m = irq_req_i;
        nxt_irq_s = irq_m_ff;
        nxt_nest_m = nest_en_i;
        nxt_nest_s = nest_m_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_m_ff <= '0;
            irq_s_ff <= '0;
            nest_m_ff <= 1'b0;
            nest_s_ff <= 1'b0;
        end else if (ce_i) begin
            irq_m_ff <= nxt_irq_m;
            irq_s_ff <= nxt_irq_s;
            nest_m_ff <= nxt_nest_m;
            nest_s_ff <= nxt_nest_s;
        end
    end

    // ==========================================
    // Take and return decisions
    cpf_pkg::cpf_state_e state_ff, nxt_state;
    logic [STAGES-1:0] valid_ff, nxt_valid;
    logic [IRQ_W-1:0] pend_ff, nxt_pend, ack_ff, nxt_ack;
    logic [IDW-1:0] id_ff, nxt_id;
    logic [3:0] cnt_ff, nxt_cnt;
    logic fetch_en_ff, nxt_fetch_en, hfetch_ff, nxt_hfetch, retire_ff, nxt_retire;
    logic svc_ff, nxt_svc;
    logic take;
    logic ret_take;
    logic [IDW-1:0] pick;

    // No take while entering: a second flush mid-entry would break the fixed latency
    always_comb begin
        pick = prio_pick(pend_ff);
        take = (|pend_ff) && (!svc_ff || nest_s_ff)
            && (state_ff == cpf_pkg::CPF_RUN || state_ff == cpf_pkg::CPF_SERVICE);
        // A take in the same cycle wins over the return
        ret_take = (state_ff == cpf_pkg::CPF_SERVICE) && isr_return_i && !take;
    end

    // ==========================================
    // Pending requests and acknowledge
    always_comb begin
        nxt_pend = pend_ff | irq_s_ff;
        nxt_ack = '0;
        nxt_id = id_ff;
        if (take) begin
            nxt_id = pick;
            nxt_ack[pick] = 1'b1;
            // A request raised again in the clearing cycle stays pending
            nxt_pend[pick] = irq_s_ff[pick];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pend_ff <= '0;
            ack_ff <= '0;
            id_ff <= '0;
        end else if (ce_i) begin
            pend_ff <= nxt_pend;
            ack_ff <= nxt_ack;
            id_ff <= nxt_id;
        end
    end

    // ==========================================
    // Stage occupancy
    always_comb begin
        // Advance one stage per cycle; entry only while fetch is enabled
        nxt_valid = {valid_ff[STAGES-2:0], fetch_valid_i & fetch_en_ff};
        nxt_retire = valid_ff[STAGES-1];
        if (take) begin
            // Drop decode_stage_two and everything younger, keep the rest
            nxt_valid[`CPF_D2_IDX:0] = '0;
        end else if (ret_take) begin
            // Return refills from fetch_stage_one; older handler slots drain
            nxt_valid[0] = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            valid_ff <= '0;
            retire_ff <= 1'b0;
        end else if (ce_i) begin
            valid_ff <= nxt_valid;
            retire_ff <= nxt_retire;
        end
    end

    // ==========================================
    // Entry and service sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_hfetch = 1'b0;
        nxt_svc = svc_ff;
        nxt_fetch_en = fetch_en_ff;
        unique case (state_ff)
            cpf_pkg::CPF_RUN, cpf_pkg::CPF_SERVICE: begin
                if (take) begin
                    nxt_fetch_en = 1'b0;
                    nxt_cnt = `CPF_ISR_LAT;
                    nxt_state = cpf_pkg::CPF_ENTER;
                end else if (ret_take) begin
                    nxt_fetch_en = 1'b1;
                    nxt_svc = 1'b0;
                    nxt_state = cpf_pkg::CPF_RUN;
                end
            end
            cpf_pkg::CPF_ENTER: begin
                // Fixed count regardless of pipeline contents keeps entry deterministic
                if (cnt_ff == `CPF_CNT_DONE) begin
                    nxt_hfetch = 1'b1;
                    nxt_fetch_en = 1'b1;
                    nxt_svc = 1'b1;
                    nxt_state = cpf_pkg::CPF_SERVICE;
                end else begin
                    nxt_cnt = cnt_ff - `CPF_CNT_STEP;
                end
            end
            cpf_pkg::CPF_DRAIN: begin
                // Never entered; falls back to run if ever reached
                nxt_state = cpf_pkg::CPF_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_ff <= cpf_pkg::CPF_RUN;
            cnt_ff <= `CPF_CNT_DONE;
            fetch_en_ff <= 1'b1;
            hfetch_ff <= 1'b0;
            svc_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fetch_en_ff <= nxt_fetch_en;
            hfetch_ff <= nxt_hfetch;
            svc_ff <= nxt_svc;
        end
    end

    assign fetch_en_o = fetch_en_ff;
    assign handler_fetch_o = hfetch_ff;
    assign handler_id_o = id_ff;
    assign stage_valid_o = valid_ff;
    assign retire_o = retire_ff;
    assign irq_ack_o = ack_ff;
    assign in_service_o = svc_ff;

endmodule

// ===== verilog/cpf_defines.svh
// Constants for the pipeline interrupt flush controller
`ifndef CPF_DEFINES_SVH
`define CPF_DEFINES_SVH

`define CPF_STAGES 8
`define CPF_D2_IDX 3
`define CPF_IRQ_W 8
`define CPF_ISR_LAT 4'h3
`define CPF_CNT_DONE 4'h0
`define CPF_CNT_STEP 4'h1

`endif

// ===== verilog/cpf_pkg.sv
// Types for the pipeline interrupt flush controller
package cpf_pkg;
    typedef enum logic [1:0] {
        CPF_RUN = 2'b00,
        CPF_DRAIN = 2'b01,
        CPF_ENTER = 2'b10,
        CPF_SERVICE = 2'b11
    } cpf_state_e;
endpackage

// ===== verification/cpf_chk.sv
// Concurrent checks on the pipeline flush controller ports
`timescale 1ns/100ps
module cpf_chk #(
    parameter int STAGES = 8,
    parameter int IRQ_W = 8
) (
    // Watched ports
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic isr_return_i,
    input wire logic nest_en_i,
    input wire logic fetch_en_o,
    input wire logic handler_fetch_o,
    input wire logic [STAGES-1:0] stage_valid_o,
    input wire logic retire_o,
    input wire logic [IRQ_W-1:0] irq_ack_o,
    input wire logic in_service_o
);
    // ====
    // Checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence s_stall; !fetch_en_o [*4]; endsequence
    sequence s_land; handler_fetch_o && fetch_en_o && in_service_o; endsequence
    a_entry_fixed: assert property (irq_ack_o != 0 |-> s_stall ##1 s_land)
        else $error("entry timing");
    a_front_flush: assert property (irq_ack_o != 0 |-> stage_valid_o[3:0] == 0)
        else $error("front kept");
    a_back_kept: assert property (irq_ack_o != 0 |->
        stage_valid_o[STAGES-1:4] == $past(stage_valid_o[STAGES-2:3]))
        else $error("back lost");
    a_hold_pending: assert property (in_service_o && !nest_en_i |-> irq_ack_o == 0)
        else $error("taken in service");
    a_retire_last: assert property (stage_valid_o[STAGES-1] && ce_i |=> retire_o)
        else $error("no retire");
    a_return_fetch: assert property (in_service_o && isr_return_i && ce_i && !nest_en_i
        |=> !in_service_o && fetch_en_o)
        else $error("return ignored");
endmodule
bind cpf_flush_ctrl cpf_chk #(.STAGES(STAGES), .IRQ_W(IRQ_W)) chk (.*);

// ===== verification/cpf_isr.sv
// Service routine and fetch path model
`timescale 1ns/100ps
module cpf_isr #(
    parameter int LEN = 8
) (
    // Controller side
    input wire logic mclk_i,
    input wire logic hf_i,
    input wire logic fe_i,
    // Toward controller
    output logic fv_o = 1'b0,
    output logic ret_o = 1'b0
);
    int cnt = 0;
    // Moves 1 ns after the edge so the controller never races it
    always @(posedge mclk_i) begin
        #1;
        fv_o = fe_i;
        cnt = hf_i ? LEN : (cnt > 0 ? cnt - 1 : 0);
        ret_o = (cnt == 1);
    end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the pipeline flush controller
`timescale 1ns/100ps
module tb;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic nest_en_i = 1'b0;
    logic [7:0] irq_req_i = 8'h00;
    logic fetch_valid_i, isr_return_i, fetch_en_o, handler_fetch_o, retire_o, in_service_o;
    logic [2:0] handler_id_o;
    logic [7:0] stage_valid_o, irq_ack_o;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2.5 mclk_i = ~mclk_i;
    cpf_flush_ctrl dut (.*);
    cpf_isr isr (.mclk_i, .hf_i(handler_fetch_o), .fe_i(fetch_en_o), .fv_o(fetch_valid_i),
        .ret_o(isr_return_i));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task wait_ack;
        for (int i = 0; i < 40 && irq_ack_o === 8'h00; i++) step(1);
    endtask
    task t_fill;
        step(10);
        chk("stages", 8'hFF, stage_valid_o);
        chk("retire", 8'h01, {7'h00, retire_o});
    endtask
    // Two requests at once: the lower index goes first, the other waits out the service
    task t_pair;
        irq_req_i = 8'h24;
        step(1);
        irq_req_i = 8'h00;
        wait_ack();
        chk("ack", 8'h04, irq_ack_o);
        chk("id", 8'h02, {5'h00, handler_id_o});
        chk("stages", 8'hF0, stage_valid_o);
        chk("fetch_en", 8'h00, {7'h00, fetch_en_o});
        step(3);
        chk("hfetch", 8'h00, {7'h00, handler_fetch_o});
        step(1);
        chk("hfetch", 8'h01, {7'h00, handler_fetch_o});
        chk("fetch_en", 8'h01, {7'h00, fetch_en_o});
        chk("service", 8'h01, {7'h00, in_service_o});
        wait_ack();
        chk("ack", 8'h20, irq_ack_o);
        chk("service", 8'h00, {7'h00, in_service_o});
        step(16);
        chk("refill", 8'h01, {7'h00, stage_valid_o[0]});
        chk("stages", 8'hEF, stage_valid_o);
    endtask
    // Clock enable low freezes the stages; a short reset empties them again
    task t_freeze;
        ce_i = 1'b0;
        step(3);
        chk("frozen", 8'hEF, stage_valid_o);
        ce_i = 1'b1;
        step(1);
        chk("stages", 8'hDF, stage_valid_o);
        srst_i = 1'b1;
        step(1);
        srst_i = 1'b0;
        chk("stages", 8'h00, stage_valid_o);
        chk("fetch_en", 8'h01, {7'h00, fetch_en_o});
    endtask
    task finish_test;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        step(6);
        srst_i = 1'b0;
        t_fill();
        t_pair();
        t_freeze();
        finish_test();
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            finish_test();
        end
    end
endmodule
